// file: emt_ext_bus.sv
// external data memory bus cycle engine with upper-port takeover
//
// Contract
// - modes 101,110,111: wide move non-multiplexed
// - 101/111 non-mux byte move: no bank
// - 110 non-mux byte move: all sixteen lines
// - modes 001,010,011: multiplexed with latch strobe
// - 001/011 mux byte move: no bank
// - 010 mux byte move: page gives upper
// - mux: upper port, shared address/data lane
// - setup before strobe zero to three cycles
// - strobe width one to sixteen cycles
// - hold after strobe zero to three cycles
// - latch strobe high one to four cycles
// - latch strobe low one to four cycles
// - write data leads strobe rise 1..19
// - write data kept for hold time
// - ports are plain pins outside moves
// - bank byte move: page upper, pointer lower byte
// - no bank byte move: upper lines from port latch
// - move lasts four plus programmed cycles
// - reset loads maximum timing settings
`timescale 1ns/10ps
module emt_ext_bus (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [2:0] i_bus_mode,
  input wire logic [1:0] i_ale_width,
  input wire logic i_timing_we,
  input wire logic [7:0] i_timing_wdata,
  input wire logic i_req,
  input wire logic i_req_wr,
  input wire logic i_req_wide,
  input wire logic [15:0] i_wide_pointer,
  input wire logic [7:0] i_byte_pointer,
  input wire logic [7:0] i_ext_page_select,
  input wire logic [7:0] i_wdata,
  input wire logic [7:0] i_gpio_hi,
  input wire logic [7:0] i_gpio_hi_oe,
  input wire logic [7:0] i_gpio_lo,
  input wire logic [7:0] i_gpio_lo_oe,
  input wire logic [7:0] i_gpio_ad,
  input wire logic [7:0] i_gpio_ad_oe,
  input wire logic [7:0] i_ad,
  output logic [7:0] o_ext_bus_timing,
  output logic o_busy,
  output logic o_done,
  output logic [7:0] o_rdata,
  output logic [7:0] o_port_hi,
  output logic [7:0] o_port_hi_oe,
  output logic [7:0] o_port_lo,
  output logic [7:0] o_port_lo_oe,
  output logic [7:0] o_port_ad,
  output logic [7:0] o_port_ad_oe,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n
);

  emt_pkg::emt_state_t state_q, state_d;
  logic [7:0] timing_q;
  logic mux_q, bank_q, wr_q, hi_drv_q;
  logic mux_d, bank_d, wr_d, hi_drv_d;
  logic [15:0] addr_q, addr_d, addr_sel;
  logic [7:0] wdata_q, wdata_d;
  logic [1:0] ale_w_q, ale_w_d;
  logic [7:0] page_q, page_d;
  logic hi_sel;
  logic go;
  logic cnt_load;
  logic [3:0] cnt_val;
  logic cnt_last;
  logic [1:0] t_setup, t_hold;
  logic [3:0] t_pulse;

  assign t_setup = timing_q[emt_pkg::SETUP_LSB +: 2];
  assign t_pulse = timing_q[emt_pkg::PULSE_LSB +: 4];
  assign t_hold = timing_q[emt_pkg::HOLD_LSB +: 2];
  assign go = i_req && emt_pkg::mode_valid(i_bus_mode);

  // --------------------------------------------------------------------
  // timing register
  // --------------------------------------------------------------------
  // writes during a move are dropped so a cycle never changes shape midway
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      timing_q <= emt_pkg::TIMING_RESET;
    end else if (i_ce && i_timing_we && state_q == emt_pkg::ST_IDLE) begin
      timing_q <= i_timing_wdata;
    end
  end

  // --------------------------------------------------------------------
  // request capture
  // --------------------------------------------------------------------
  emt_addr_sel u_addr_sel (
    .i_wide(i_req_wide),
    .i_bank(emt_pkg::mode_bank(i_bus_mode)),
    .i_wide_pointer(i_wide_pointer),
    .i_byte_pointer(i_byte_pointer),
    .i_page(i_ext_page_select),
    .o_addr(addr_sel),
    .o_hi_drive(hi_sel)
  );

  always_comb begin
    if (state_q == emt_pkg::ST_IDLE && go) begin
      mux_d = emt_pkg::mode_mux(i_bus_mode);
      bank_d = emt_pkg::mode_bank(i_bus_mode);
      wr_d = i_req_wr;
      hi_drv_d = hi_sel;
      addr_d = addr_sel;
      wdata_d = i_wdata;
      ale_w_d = i_ale_width;
      page_d = i_ext_page_select;
    end else begin
      mux_d = mux_q;
      bank_d = bank_q;
      wr_d = wr_q;
      hi_drv_d = hi_drv_q;
      addr_d = addr_q;
      wdata_d = wdata_q;
      ale_w_d = ale_w_q;
      page_d = page_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      mux_q <= 1'b0;
      bank_q <= 1'b0;
      wr_q <= 1'b0;
      hi_drv_q <= 1'b0;
      addr_q <= 16'h0000;
      wdata_q <= 8'h00;
      ale_w_q <= emt_pkg::ALE_WIDTH_RESET;
      page_q <= 8'h00;
    end else if (i_ce) begin
      mux_q <= mux_d;
      bank_q <= bank_d;
      wr_q <= wr_d;
      hi_drv_q <= hi_drv_d;
      addr_q <= addr_d;
      wdata_q <= wdata_d;
      ale_w_q <= ale_w_d;
      page_q <= page_d;
    end
  end

  // --------------------------------------------------------------------
  // cycle sequencer
  // --------------------------------------------------------------------
  emt_phase_cnt #(.W(4)) u_phase_cnt (
    .i_clk(i_clk),
    .i_sys_rst(i_sys_rst),
    .i_ce(i_ce),
    .i_load(cnt_load),
    .i_val(cnt_val),
    .o_last(cnt_last)
  );

  always_comb begin
    state_d = state_q;
    cnt_load = 1'b0;
    cnt_val = 4'h0;
    case (state_q)
      emt_pkg::ST_IDLE: begin
        if (go) begin
          state_d = emt_pkg::ST_START;
        end
      end
      emt_pkg::ST_START, emt_pkg::ST_ALEL: begin
        if (state_q == emt_pkg::ST_START && mux_q) begin
          state_d = emt_pkg::ST_ALEH;
          cnt_load = 1'b1;
          cnt_val = {2'b00, ale_w_q};
        end else if (cnt_last && t_setup != 2'h0) begin
          state_d = emt_pkg::ST_SETUP;
          cnt_load = 1'b1;
          cnt_val = {2'b00, t_setup - 2'h1};
        end else if (cnt_last) begin
          state_d = emt_pkg::ST_STROBE;
          cnt_load = 1'b1;
          cnt_val = t_pulse;
        end
      end
      emt_pkg::ST_ALEH: begin
        if (cnt_last) begin
          state_d = emt_pkg::ST_ALEL;
          cnt_load = 1'b1;
          cnt_val = {2'b00, ale_w_q};
        end
      end
      emt_pkg::ST_SETUP: begin
        if (cnt_last) begin
          state_d = emt_pkg::ST_STROBE;
          cnt_load = 1'b1;
          cnt_val = t_pulse;
        end
      end
      emt_pkg::ST_STROBE: begin
        if (cnt_last && t_hold != 2'h0) begin
          state_d = emt_pkg::ST_HOLD;
          cnt_load = 1'b1;
          cnt_val = {2'b00, t_hold - 2'h1};
        end else if (cnt_last) begin
          state_d = emt_pkg::ST_FIN;
          cnt_load = 1'b1;
          cnt_val = emt_pkg::FIN_LOAD;
        end
      end
      emt_pkg::ST_HOLD: begin
        if (cnt_last) begin
          state_d = emt_pkg::ST_FIN;
          cnt_load = 1'b1;
          cnt_val = emt_pkg::FIN_LOAD;
        end
      end
      emt_pkg::ST_FIN: begin
        if (cnt_last) begin
          state_d = emt_pkg::ST_IDLE;
        end
      end
      default: begin
        state_d = emt_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_q <= emt_pkg::ST_IDLE;
    end else if (i_ce) begin
      state_q <= state_d;
    end
  end

  // --------------------------------------------------------------------
  // pins, registered from the next state
  // --------------------------------------------------------------------
  logic bus_d, addr_ph_d, data_ph_d;
  assign bus_d = (state_d != emt_pkg::ST_IDLE);
  assign addr_ph_d = (state_d == emt_pkg::ST_START) || (state_d == emt_pkg::ST_ALEH) ||
                     (state_d == emt_pkg::ST_ALEL);
  assign data_ph_d = (state_d == emt_pkg::ST_SETUP) || (state_d == emt_pkg::ST_STROBE) ||
                     (state_d == emt_pkg::ST_HOLD);

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_port_hi <= 8'h00;
      o_port_hi_oe <= 8'h00;
    end else if (i_ce) begin
      if (bus_d && hi_drv_d) begin
        o_port_hi <= addr_d[15:8];
        o_port_hi_oe <= 8'hff;
      end else begin
        o_port_hi <= i_gpio_hi;
        o_port_hi_oe <= i_gpio_hi_oe;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_port_lo <= 8'h00;
      o_port_lo_oe <= 8'h00;
    end else if (i_ce) begin
      if (bus_d && !mux_d) begin
        o_port_lo <= addr_d[7:0];
        o_port_lo_oe <= 8'hff;
      end else begin
        o_port_lo <= i_gpio_lo;
        o_port_lo_oe <= i_gpio_lo_oe;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_port_ad <= 8'h00;
      o_port_ad_oe <= 8'h00;
    end else if (i_ce) begin
      if (!bus_d) begin
        o_port_ad <= i_gpio_ad;
        o_port_ad_oe <= i_gpio_ad_oe;
      end else if (mux_d && addr_ph_d) begin
        o_port_ad <= addr_d[7:0];
        o_port_ad_oe <= 8'hff;
      end else if (wr_d && data_ph_d) begin
        o_port_ad <= wdata_d;
        o_port_ad_oe <= 8'hff;
      end else begin
        o_port_ad <= 8'h00;
        o_port_ad_oe <= 8'h00;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_ale <= 1'b0;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_busy <= 1'b0;
    end else if (i_ce) begin
      o_ale <= mux_d && (state_d == emt_pkg::ST_ALEH);
      o_rd_n <= !((state_d == emt_pkg::ST_STROBE) && !wr_d);
      o_wr_n <= !((state_d == emt_pkg::ST_STROBE) && wr_d);
      o_busy <= bus_d;
    end
  end

  // --------------------------------------------------------------------
  // read capture and completion
  // --------------------------------------------------------------------
  // sampled on the last strobe cycle, the latest point the memory drives
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      o_rdata <= 8'h00;
      o_done <= 1'b0;
    end else if (i_ce) begin
      if (state_q == emt_pkg::ST_STROBE && cnt_last && !wr_q) begin
        o_rdata <= i_ad;
      end
      o_done <= (state_q == emt_pkg::ST_FIN) && cnt_last;
    end else begin
      o_done <= 1'b0;
    end
  end

  assign o_ext_bus_timing = timing_q;

  // --------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------
  logic [7:0] cyc_cnt_q, ph_cnt_q, cyc_exp;
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cyc_cnt_q <= 8'h00;
      ph_cnt_q <= 8'h00;
    end else if (i_ce) begin
      cyc_cnt_q <= (state_q == emt_pkg::ST_IDLE) ? 8'h00 : cyc_cnt_q + 8'h01;
      ph_cnt_q <= (state_d != state_q) ? 8'h00 : ph_cnt_q + 8'h01;
    end
  end
  assign cyc_exp = emt_pkg::BASE_CYCLES + {6'h00, t_setup} + {4'h0, t_pulse} + 8'h01 + {6'h00, t_hold} +
                   (mux_q ? {5'h00, ale_w_q, 1'b0} + 8'h02 : 8'h00);

  sequence s_leave(emt_pkg::emt_state_t st);
    i_ce && state_q == st && state_d != st;
  endsequence

  sequence s_wr_end;
    $rose(o_wr_n);
  endsequence

  chk_move_length: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_leave(emt_pkg::ST_FIN) |-> cyc_cnt_q == cyc_exp - 8'h01)
    else $error("move length wrong");
  chk_strobe_width: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_leave(emt_pkg::ST_STROBE) |-> ph_cnt_q == {4'h0, t_pulse})
    else $error("strobe width wrong");
  chk_setup_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_leave(emt_pkg::ST_SETUP) |-> ph_cnt_q + 8'h01 == {6'h00, t_setup})
    else $error("setup length wrong");
  chk_hold_len: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_leave(emt_pkg::ST_HOLD) |-> ph_cnt_q + 8'h01 == {6'h00, t_hold})
    else $error("hold length wrong");
  chk_ale_high: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_leave(emt_pkg::ST_ALEH) |-> ph_cnt_q == {6'h00, ale_w_q} && o_ale)
    else $error("latch strobe high time wrong");
  chk_ale_low: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_leave(emt_pkg::ST_ALEL) |-> ph_cnt_q == {6'h00, ale_w_q} && !o_ale && o_rd_n && o_wr_n)
    else $error("latch strobe low time wrong");
  chk_ale_nonmux: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_busy && !mux_q |-> !o_ale && o_port_lo_oe == 8'hff && o_port_lo == addr_q[7:0])
    else $error("latch strobe in non-multiplexed cycle");
  chk_wdata_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    s_wr_end and (t_hold != 2'h0) |-> o_port_ad_oe == 8'hff && o_port_ad == wdata_q)
    else $error("write data dropped during hold");
  chk_wdata_lead: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $fell(o_wr_n) |-> o_port_ad_oe == 8'hff && o_port_ad == wdata_q)
    else $error("write data not ahead of strobe");
  chk_bank_upper: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_busy && bank_q && hi_drv_q |-> o_port_hi_oe == 8'hff && o_port_hi == addr_q[15:8])
    else $error("upper address byte wrong");
  chk_idle_gpio: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    $past(i_ce) && !o_busy && !$past(o_busy) && !$past(i_sys_rst) |->
      o_port_hi == $past(i_gpio_hi) && o_port_ad_oe == $past(i_gpio_ad_oe))
    else $error("port not released outside move");
  chk_reset_timing: assert property (@(posedge i_clk)
    $past(i_sys_rst) |-> timing_q == emt_pkg::TIMING_RESET)
    else $error("timing not at maximum after reset");

endmodule : emt_ext_bus

// file: emt_pkg.sv
// constants shared by the external memory bus timing block
package emt_pkg;

  // --------------------------------------------------------------------
  // bus mode field codes
  // --------------------------------------------------------------------
  localparam logic [2:0] MODE_MUX_NOBANK_A = 3'h1;
  localparam logic [2:0] MODE_MUX_BANK = 3'h2;
  localparam logic [2:0] MODE_MUX_NOBANK_B = 3'h3;
  localparam logic [2:0] MODE_NMX_NOBANK_A = 3'h5;
  localparam logic [2:0] MODE_NMX_BANK = 3'h6;
  localparam logic [2:0] MODE_NMX_NOBANK_B = 3'h7;

  // --------------------------------------------------------------------
  // timing register layout and reset value
  // --------------------------------------------------------------------
  localparam int SETUP_LSB = 6;
  localparam int PULSE_LSB = 2;
  localparam int HOLD_LSB = 0;
  localparam logic [7:0] TIMING_RESET = 8'hff;
  localparam logic [1:0] ALE_WIDTH_RESET = 2'h3;

  // --------------------------------------------------------------------
  // cycle counts
  // --------------------------------------------------------------------
  localparam logic [7:0] BASE_CYCLES = 8'h04;
  localparam logic [3:0] FIN_LOAD = 4'h2;
  localparam logic [3:0] START_CYCLES = 4'h1;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_START,
    ST_ALEH,
    ST_ALEL,
    ST_SETUP,
    ST_STROBE,
    ST_HOLD,
    ST_FIN
  } emt_state_t;

  function automatic logic mode_valid(input logic [2:0] m);
    mode_valid = (m != 3'h0) && (m != 3'h4);
  endfunction : mode_valid

  function automatic logic mode_mux(input logic [2:0] m);
    mode_mux = !m[2];
  endfunction : mode_mux

  function automatic logic mode_bank(input logic [2:0] m);
    mode_bank = (m == MODE_MUX_BANK) || (m == MODE_NMX_BANK);
  endfunction : mode_bank

endpackage : emt_pkg

// file: emt_phase_cnt.sv
// down-counter that times each phase of a bus cycle
`timescale 1ns/10ps
module emt_phase_cnt #(
  parameter int W = 4
) (
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic i_load,
  input wire logic [W-1:0] i_val,
  output logic o_last
);

  logic [W-1:0] cnt_q;

  // --------------------------------------------------------------------
  // count
  // --------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      cnt_q <= '0;
    end else if (i_ce) begin
      if (i_load) begin
        cnt_q <= i_val;
      end else if (cnt_q != '0) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

  assign o_last = (cnt_q == '0);

endmodule : emt_phase_cnt

// file: emt_addr_sel.sv
// forms the effective address and upper byte drive for one move
`timescale 1ns/10ps
module emt_addr_sel (
  input wire logic i_wide,
  input wire logic i_bank,
  input wire logic [15:0] i_wide_pointer,
  input wire logic [7:0] i_byte_pointer,
  input wire logic [7:0] i_page,
  output logic [15:0] o_addr,
  output logic o_hi_drive
);

  // --------------------------------------------------------------------
  // address forming
  // --------------------------------------------------------------------
  always_comb begin
    if (i_wide) begin
      o_addr = i_wide_pointer;
      o_hi_drive = 1'b1;
    end else begin
      o_addr = {i_page, i_byte_pointer};
      // without bank the upper byte stays with the port latch
      o_hi_drive = i_bank;
    end
  end

endmodule : emt_addr_sel

// file: emt_mem_model.sv
// behavioural byte-wide asynchronous memory on the far side of the bus
`timescale 1ns/10ps
module emt_mem_model (
  input wire logic i_clk,
  input wire logic i_mux,
  input wire logic [3:0] i_lat,
  input wire logic i_ale,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [7:0] i_hi,
  input wire logic [7:0] i_lo,
  input wire logic [7:0] i_ad,
  output logic [7:0] o_ad
);
  // ------------------------------------------------------------------
  // address latch and storage
  // ------------------------------------------------------------------
  logic [7:0] mem [0:65535];
  logic [7:0] lo_latch_q;
  logic [7:0] ad_last_q;
  logic [3:0] low_cnt_q;
  logic [15:0] addr;

  assign addr = {i_hi, i_mux ? lo_latch_q : i_lo};

  always_ff @(posedge i_clk) begin
    if (i_ale) begin
      lo_latch_q <= i_ad;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_wr_n) begin
      mem[addr] <= i_ad;
    end
  end

  // ------------------------------------------------------------------
  // read answer
  // ------------------------------------------------------------------
  // slow parts give valid data only after i_lat strobe cycles
  always_ff @(posedge i_clk) begin
    ad_last_q <= i_ad;
    low_cnt_q <= i_rd_n ? 4'h0 : low_cnt_q + {3'h0, low_cnt_q != 4'hf};
  end

  // released lane shows the inverse of its last level, never a stale value
  assign o_ad = (!i_rd_n && low_cnt_q >= i_lat) ? mem[addr] : ~ad_last_q;
endmodule : emt_mem_model

// file: emt_ext_bus_tb_top.sv
// self-checking bench for the external memory bus cycle engine
`timescale 1ns/10ps
module emt_ext_bus_tb_top;
  // ------------------------------------------------------------------
  // stimulus and observation signals
  // ------------------------------------------------------------------
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic [2:0] bus_mode = 3'h1;
  logic [1:0] ale_width = 2'h0;
  logic timing_we = 1'b0;
  logic ce = 1'b1;
  logic [7:0] timing_wdata = 8'h00;
  logic req = 1'b0, req_wr = 1'b0, req_wide = 1'b0;
  logic [15:0] wide_ptr = 16'h0000;
  logic [7:0] byte_ptr = 8'h00, page = 8'h00, wdata = 8'h00;
  logic [7:0] gp_hi = 8'h00, gp_hi_oe = 8'h00, gp_lo = 8'h00, gp_lo_oe = 8'h00;
  logic [7:0] gp_ad = 8'h00, gp_ad_oe = 8'h00;
  logic [3:0] lat = 4'h0;
  logic [7:0] timing_rb, rdata, port_hi, port_hi_oe, port_lo, port_lo_oe, port_ad, port_ad_oe, mem_ad;
  logic [7:0] ad_pin, hi_pin;
  logic busy, done, ale, rd_n, wr_n;
  int n_errors = 0;
  int checked = 0;
  logic [9:0][15:0] exp_q[$];
  logic [7:0] tv = emt_pkg::TIMING_RESET;
  logic [15:0] addr_g;
  logic [7:0] wd_g;
  string fname [10] = '{"cycles", "setup", "ale_high", "strobe", "after", "wd_lead", "wd_keep", "upper",
                        "lower", "rdata"};

  assign ad_pin = (port_ad & port_ad_oe) | (mem_ad & ~port_ad_oe);
  assign hi_pin = (port_hi & port_hi_oe) | ~port_hi_oe;

  emt_ext_bus emt_ext_bus_inst (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_ce(ce), .i_bus_mode(bus_mode),
    .i_ale_width(ale_width), .i_timing_we(timing_we), .i_timing_wdata(timing_wdata), .i_req(req),
    .i_req_wr(req_wr), .i_req_wide(req_wide), .i_wide_pointer(wide_ptr), .i_byte_pointer(byte_ptr),
    .i_ext_page_select(page), .i_wdata(wdata), .i_gpio_hi(gp_hi), .i_gpio_hi_oe(gp_hi_oe),
    .i_gpio_lo(gp_lo), .i_gpio_lo_oe(gp_lo_oe), .i_gpio_ad(gp_ad), .i_gpio_ad_oe(gp_ad_oe), .i_ad(ad_pin),
    .o_ext_bus_timing(timing_rb), .o_busy(busy), .o_done(done), .o_rdata(rdata), .o_port_hi(port_hi),
    .o_port_hi_oe(port_hi_oe), .o_port_lo(port_lo), .o_port_lo_oe(port_lo_oe), .o_port_ad(port_ad),
    .o_port_ad_oe(port_ad_oe), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n));

  emt_mem_model emt_mem_model_inst (.i_clk(i_clk), .i_mux(!bus_mode[2]), .i_lat(lat), .i_ale(ale),
    .i_rd_n(rd_n), .i_wr_n(wr_n), .i_hi(hi_pin), .i_lo(port_lo), .i_ad(ad_pin), .o_ad(mem_ad));

  // ------------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------------
  task cmp(input string what, input logic [15:0] exp, input logic [15:0] got);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp

  task conclude;
    $display("counts: checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude

  // new mode, port latches and optionally new timing, all while idle
  task prep(input logic [2:0] mode, input logic prog, input logic [7:0] v);
    @(posedge i_clk);
    bus_mode <= mode;
    timing_we <= prog;
    timing_wdata <= v;
    ale_width <= prog ? 2'($urandom) : ale_width;
    gp_hi <= 8'($urandom);
    gp_hi_oe <= 8'($urandom);
    page <= 8'($urandom);
    @(posedge i_clk);
    timing_we <= 1'b0;
    if (prog) begin
      tv = v;
    end
    @(negedge i_clk);
    cmp("timing_readback", {8'h00, tv}, {8'h00, timing_rb});
    lat <= 4'($urandom % (tv[5:2] + 1));
  endtask : prep

  task op(input logic wr, input logic wide);
    logic [9:0][15:0] e;
    int s, p, h, a, n;
    s = tv[7:6];
    p = tv[5:2];
    h = tv[1:0];
    a = bus_mode[2] ? 0 : 2 * (ale_width + 1);
    e[0] = 16'(4 + s + p + 1 + h + a);
    e[1] = 16'(1 + s + a);
    e[2] = 16'(a / 2);
    e[3] = 16'(p + 1);
    e[4] = 16'(h + 3);
    e[5] = wr ? 16'(s + p + 1) : 16'h0000;
    e[6] = wr ? 16'(h) : 16'h0000;
    e[7] = wide ? {8'h00, addr_g[15:8]} : (bus_mode[1:0] == 2'h2) ? {8'h00, page} : {8'h00, gp_hi | ~gp_hi_oe};
    e[8] = {8'h00, addr_g[7:0]};
    e[9] = wr ? 16'h0000 : {8'h00, wd_g};
    @(posedge i_clk);
    req <= 1'b1;
    req_wr <= wr;
    req_wide <= wide;
    wide_ptr <= addr_g;
    byte_ptr <= addr_g[7:0];
    wdata <= wd_g;
    exp_q.push_back(e);
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (busy !== 1'b1 && n < 8);
    @(posedge i_clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(negedge i_clk);
      n++;
    end while (done !== 1'b1 && n < 64);
  endtask : op

  // ------------------------------------------------------------------
  // monitor: measures each move and takes the oldest note
  // ------------------------------------------------------------------
  logic [9:0][15:0] got, e_m;
  logic in_move = 1'b0, wr_seen = 1'b0;
  always @(negedge i_clk) begin
    if (busy === 1'b1) begin
      if (!in_move) begin
        got = '0;
        wr_seen = 1'b0;
        in_move = 1'b1;
      end
      got[0]++;
      if (ale === 1'b1) begin
        got[2]++;
        got[8] = {8'h00, port_ad};
      end
      if (rd_n === 1'b0 || wr_n === 1'b0) begin
        got[3]++;
        got[7] = {8'h00, hi_pin};
        wr_seen = wr_seen | (wr_n === 1'b0);
        if (bus_mode[2]) begin
          got[8] = {8'h00, port_lo};
        end
      end else if (got[3] == 0) begin
        got[1]++;
      end else begin
        got[4]++;
      end
      if (port_ad_oe === 8'hff && port_ad === wd_g && ale !== 1'b1) begin
        if (got[4] == 0) got[5]++;
        else got[6]++;
      end
    end else if (in_move) begin
      in_move = 1'b0;
      got[9] = wr_seen ? 16'h0000 : {8'h00, rdata};
      cmp("done_pulse", 16'h0001, {15'h0000, done});
      if (exp_q.size() == 0) begin
        cmp("queue", 16'h0001, 16'h0000);
      end else begin
        e_m = exp_q.pop_front();
        for (int i = 0; i < 10; i++) begin
          cmp(fname[i], e_m[i], got[i]);
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // clock, reset, watchdog
  // ------------------------------------------------------------------
  initial begin
    forever #5 i_clk = ~i_clk;
  end

  // 48 moves of at most 40 cycles each fit well inside this span
  initial begin
    #200000;
    n_errors++;
    $display("Error watchdog expected finish seen timeout");
    conclude();
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin : main
    logic [2:0] modes [6];
    modes = '{emt_pkg::MODE_MUX_NOBANK_A, emt_pkg::MODE_MUX_BANK, emt_pkg::MODE_MUX_NOBANK_B,
              emt_pkg::MODE_NMX_NOBANK_A, emt_pkg::MODE_NMX_BANK, emt_pkg::MODE_NMX_NOBANK_B};
    void'($urandom(32'h24ef));
    repeat (6) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    @(negedge i_clk);
    cmp("timing_reset", {8'h00, emt_pkg::TIMING_RESET}, {8'h00, timing_rb});
    @(posedge i_clk);
    gp_lo <= 8'($urandom);
    gp_lo_oe <= 8'($urandom);
    gp_ad <= 8'($urandom);
    gp_ad_oe <= 8'($urandom);
    repeat (2) @(negedge i_clk);
    cmp("idle_lo", {gp_lo_oe, gp_lo}, {port_lo_oe, port_lo});
    cmp("idle_ad", {gp_ad_oe, gp_ad}, {port_ad_oe, port_ad});
    // enable low must freeze the pins even though the latch input moves
    @(posedge i_clk);
    ce <= 1'b0;
    gp_lo <= ~gp_lo;
    repeat (2) @(negedge i_clk);
    cmp("ce_freeze", {gp_lo_oe, ~gp_lo}, {port_lo_oe, port_lo});
    @(posedge i_clk);
    ce <= 1'b1;
    repeat (2) @(negedge i_clk);
    cmp("ce_resume", {gp_lo_oe, gp_lo}, {port_lo_oe, port_lo});
    $display("test reset and idle pins done");
    for (int m = 0; m < 2; m++) begin
      @(posedge i_clk);
      bus_mode <= m[0] ? 3'h4 : 3'h0;
      req <= 1'b1;
      repeat (4) @(negedge i_clk);
      cmp("refused_busy", 16'h0000, {15'h0000, busy});
      @(posedge i_clk);
      req <= 1'b0;
    end
    $display("test refused modes done");
    for (int m = 0; m < 6; m++) begin
      for (int k = 0; k < 4; k++) begin
        prep(modes[m], !(m == 0 && k == 0), (k == 1) ? 8'h00 : 8'($urandom));
        addr_g = 16'($urandom);
        wd_g = 8'($urandom);
        if (wd_g == addr_g[7:0]) wd_g = ~wd_g;
        op(1'b1, k[0]);
        op(1'b0, k[0]);
      end
      $display("test mode %h done", modes[m]);
    end
    repeat (3) @(negedge i_clk);
    cmp("idle_after", {gp_lo_oe, gp_lo}, {port_lo_oe, port_lo});
    cmp("pending", 16'h0000, 16'(exp_q.size()));
    conclude();
  end
endmodule : emt_ext_bus_tb_top
